// ==== hw/gppm_pkg.sv ====
package gppm_pkg;
  localparam int unsigned GPPM_PINS = 16;
  localparam logic [7:0] GPPM_OFF_CFG = 8'h00;
  localparam logic [7:0] GPPM_OFF_DIR = 8'h04;
  localparam logic [7:0] GPPM_OFF_VAL = 8'h08;
  localparam logic [7:0] GPPM_OFF_MASK = 8'h0c;
  localparam logic [7:0] GPPM_OFF_STAT = 8'h10;
  localparam logic [7:0] GPPM_OFF_CLR = 8'h14;
  localparam logic [7:0] GPPM_OFF_EN = 8'h18;
  localparam logic [7:0] GPPM_OFF_MODE = 8'h1c;
  localparam int unsigned GPPM_CFG_LSB = 0;
  localparam logic [2:0] GPPM_CFG_ADDR = 3'h0;
  localparam logic [2:0] GPPM_CFG_PORT = 3'h4;
  localparam logic [2:0] GPPM_CFG_RST = 3'h0;
  localparam logic [15:0] GPPM_DIR_RST = 16'h0000;
  localparam logic [15:0] GPPM_MASK_RST = 16'hffff;
  localparam logic [15:0] GPPM_EN_RST = 16'hffff;
  localparam logic [1:0] GPPM_RESP_OKAY = 2'h0;
  localparam logic [1:0] GPPM_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [15:0] in;
    logic [15:0] out;
    logic [15:0] oe;
  } gppm_pins_t;

  typedef struct packed {
    logic        bus_mode_select;
    logic        dir_wr_in;
    logic        dir_wr_out;
    logic        dir_wr_oe;
  } gppm_mode_t;
endpackage

// ==== hw/gppm_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module gppm_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic bus_mode_select_i,
  input wire logic wr_dir_i,
  input wire logic [15:0] local_bus_address_i,
  input wire logic [15:0] port_pins_i,
  output logic [15:0] port_pins_o,
  output logic [15:0] port_pins_oe_o,
  output logic wr_dir_o,
  output logic wr_dir_oe_o,
  output logic bus_mode_select_write_o,
  output logic interrupt_request_out_o
);
  import gppm_pkg::*;

  // ****************************************
  // register write path
  // ****************************************
  logic aw_hold_ff, w_hold_ff, bvalid_ff;
  logic nxt_aw_hold, nxt_w_hold, nxt_bvalid;
  logic [7:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic [1:0] bresp_ff, nxt_bresp;
  logic [2:0] cfg_ff, nxt_cfg;
  logic [15:0] dir_ff, nxt_dir, val_ff, nxt_val, mask_ff, nxt_mask;
  logic [15:0] en_ff, nxt_en, stat_ff, nxt_stat;
  logic [15:0] sync1_ff, sync2_ff, prev_ff, nxt_prev;
  logic wr_fire;
  logic [15:0] clr_bits, chg;

  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    wr16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'h0) && (a <= GPPM_OFF_MODE);
  endfunction

  assign s_axi_awready_o = !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready_o = !w_hold_ff && !bvalid_ff;
  assign wr_fire = aw_hold_ff && w_hold_ff && !bvalid_ff;
  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o = bresp_ff;

  // port is only a port in PCI mode with config 100
  logic pci_mode, port_mode, addr_mode;
  assign pci_mode = !bus_mode_select_i;
  assign port_mode = pci_mode && (cfg_ff == GPPM_CFG_PORT);
  assign addr_mode = pci_mode && (cfg_ff == GPPM_CFG_ADDR);

  // input change: compare consecutive synchronized samples, only for input pins
  assign chg = (sync2_ff ^ prev_ff) & ~dir_ff & {16{port_mode}};

  always_comb begin
    nxt_aw_hold = aw_hold_ff;
    nxt_w_hold = w_hold_ff;
    nxt_bvalid = bvalid_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bresp = bresp_ff;
    nxt_cfg = cfg_ff;
    nxt_dir = dir_ff;
    nxt_val = val_ff;
    nxt_mask = mask_ff;
    nxt_en = en_ff;
    clr_bits = 16'h0000;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      nxt_aw_hold = 1'b1;
      nxt_awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      nxt_w_hold = 1'b1;
      nxt_wdata = s_axi_wdata_i;
      nxt_wstrb = s_axi_wstrb_i;
    end
    if (wr_fire) begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = is_mapped(awaddr_ff) ? GPPM_RESP_OKAY : GPPM_RESP_SLVERR;
      case (awaddr_ff)
        GPPM_OFF_CFG: begin
          if (wstrb_ff[0]) begin
            nxt_cfg = wdata_ff[GPPM_CFG_LSB +: 3];
          end
        end
        GPPM_OFF_DIR: nxt_dir = wr16(dir_ff, wdata_ff, wstrb_ff);
        GPPM_OFF_VAL: nxt_val = wr16(val_ff, wdata_ff, wstrb_ff);
        GPPM_OFF_MASK: nxt_mask = wr16(mask_ff, wdata_ff, wstrb_ff);
        GPPM_OFF_CLR: clr_bits = wr16(16'h0000, wdata_ff, wstrb_ff);
        GPPM_OFF_EN: nxt_en = wr16(en_ff, wdata_ff, wstrb_ff);
        default: begin
        end
      endcase
    end else if (bvalid_ff && s_axi_bready_i) begin
      nxt_bvalid = 1'b0;
    end
    // set wins over clear
    nxt_stat = (stat_ff & ~clr_bits) | chg;
    nxt_prev = sync2_ff;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bresp_ff <= GPPM_RESP_OKAY;
      cfg_ff <= GPPM_CFG_RST;
      dir_ff <= GPPM_DIR_RST;
      val_ff <= 16'h0000;
      mask_ff <= GPPM_MASK_RST;
      en_ff <= GPPM_EN_RST;
      stat_ff <= 16'h0000;
      sync1_ff <= 16'h0000;
      sync2_ff <= 16'h0000;
      prev_ff <= 16'h0000;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff <= nxt_w_hold;
      bvalid_ff <= nxt_bvalid;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bresp_ff <= nxt_bresp;
      cfg_ff <= nxt_cfg;
      dir_ff <= nxt_dir;
      val_ff <= nxt_val;
      mask_ff <= nxt_mask;
      en_ff <= nxt_en;
      stat_ff <= nxt_stat;
      sync1_ff <= port_pins_i;
      sync2_ff <= sync1_ff;
      prev_ff <= nxt_prev;
    end
  end

  // ****************************************
  // register read path
  // ****************************************
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [15:0] val_rd;

  // outputs read back their driven value, inputs their synchronized level
  assign val_rd = (dir_ff & val_ff) | (~dir_ff & sync2_ff);
  assign s_axi_arready_o = !rvalid_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rdata_o = rdata_ff;
  assign s_axi_rresp_o = rresp_ff;

  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = is_mapped(s_axi_araddr_i) ? GPPM_RESP_OKAY : GPPM_RESP_SLVERR;
      case (s_axi_araddr_i)
        GPPM_OFF_CFG: nxt_rdata = {29'h0, cfg_ff};
        GPPM_OFF_DIR: nxt_rdata = {16'h0, dir_ff};
        GPPM_OFF_VAL: nxt_rdata = {16'h0, val_rd};
        GPPM_OFF_MASK: nxt_rdata = {16'h0, mask_ff};
        GPPM_OFF_STAT: nxt_rdata = {16'h0, stat_ff};
        GPPM_OFF_EN: nxt_rdata = {16'h0, en_ff};
        GPPM_OFF_MODE: nxt_rdata = {30'h0, port_mode, bus_mode_select_i};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end else if (rvalid_ff && s_axi_rready_i) begin
      nxt_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= GPPM_RESP_OKAY;
    end else begin
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  // ****************************************
  // pins and interrupt
  // ****************************************
  logic [15:0] pins_q_ff, nxt_pins_q, oe_q_ff, nxt_oe_q;
  logic irq_ff, nxt_irq;

  always_comb begin
    nxt_pins_q = 16'h0000;
    nxt_oe_q = 16'h0000;
    if (addr_mode) begin
      nxt_pins_q = local_bus_address_i;
      nxt_oe_q = 16'hffff;
    end else if (port_mode) begin
      nxt_pins_q = val_ff & dir_ff;
      nxt_oe_q = dir_ff;
    end
    // mask set means suppressed; enable register gates as well
    // next mask and enable, so the pin never lags a mask or enable write by a cycle
    nxt_irq = |(nxt_stat & ~nxt_mask & nxt_en);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pins_q_ff <= 16'h0000;
      oe_q_ff <= 16'h0000;
      irq_ff <= 1'b0;
    end else begin
      pins_q_ff <= nxt_pins_q;
      oe_q_ff <= nxt_oe_q;
      irq_ff <= nxt_irq;
    end
  end

  assign port_pins_o = pins_q_ff;
  assign port_pins_oe_o = oe_q_ff;
  assign interrupt_request_out_o = irq_ff;
  // write/read pin is sensed only, never driven by this block
  assign wr_dir_o = 1'b0;
  assign wr_dir_oe_o = 1'b0;
  assign bus_mode_select_write_o = bus_mode_select_i && wr_dir_i;

  // ****************************************
  // checks
  // ****************************************
  a_wr_pin_released: assert property (@(posedge clk_i) disable iff (rst_i) !wr_dir_oe_o)
    else $error("write/read pin driven");
  a_pci_no_write: assert property (@(posedge clk_i) disable iff (rst_i) !bus_mode_select_i |-> !bus_mode_select_write_o)
    else $error("write strobe seen in PCI mode");
  // the antecedents skip the edge that still samples reset, whose outputs are the reset values
  a_addr_mode_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i && addr_mode |=> port_pins_oe_o == 16'hffff)
    else $error("address pins not driven");
  a_out_from_value: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i && port_mode |=> ((port_pins_o & port_pins_oe_o) == ($past(val_ff) & $past(dir_ff))))
    else $error("output pin not from value register");
  a_dir_drives_oe: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i && port_mode |=> port_pins_oe_o == $past(dir_ff))
    else $error("direction not applied");
  a_bus_mode_select_no_port: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_mode_select_i |=> port_pins_oe_o == 16'h0000)
    else $error("pins driven in bus_mode_select mode");
  a_change_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    (chg != 16'h0000) |=> ((stat_ff & $past(chg)) == $past(chg)))
    else $error("change not captured");
  a_sync_two: assert property (@(posedge clk_i) disable iff (rst_i)
    (!$past(rst_i) && !$past(rst_i, 2)) |-> (sync2_ff == $past(port_pins_i, 2)))
    else $error("synchronizer depth wrong");
  a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
    interrupt_request_out_o == |(stat_ff & ~mask_ff & en_ff))
    else $error("interrupt level mismatch");
  a_mask_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
    (mask_ff == 16'hffff) |-> !interrupt_request_out_o)
    else $error("masked interrupt seen");
  a_read_input: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == GPPM_OFF_VAL) |=>
    (s_axi_rdata_o[15:0] & ~$past(dir_ff)) == ($past(sync2_ff) & ~$past(dir_ff)))
    else $error("input readback wrong");
  a_cfg_port_only: assert property (@(posedge clk_i) disable iff (rst_i)
    (!rst_i && !bus_mode_select_i && cfg_ff == GPPM_CFG_PORT) |=> port_pins_oe_o == $past(dir_ff))
    else $error("port config not applied to pins");
  a_cfg_other_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (!rst_i && cfg_ff != GPPM_CFG_ADDR && cfg_ff != GPPM_CFG_PORT) |=> port_pins_oe_o == 16'h0000)
    else $error("pins driven under another config");

  c_irq_raise: cover property (@(posedge clk_i) disable iff (rst_i) $rose(interrupt_request_out_o));
  c_port_out: cover property (@(posedge clk_i) disable iff (rst_i) port_mode && dir_ff != 16'h0000);
  c_write_done: cover property (@(posedge clk_i) disable iff (rst_i) s_axi_bvalid_o && s_axi_bready_i);
  c_addr_mode: cover property (@(posedge clk_i) disable iff (rst_i) addr_mode);
  c_change_seen: cover property (@(posedge clk_i) disable iff (rst_i) chg != 16'h0000);
endmodule
`default_nettype wire

// ==== verif/gppm_pins_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module gppm_pins_model (
  input wire gppm_pkg::gppm_pins_t dev_i,
  input wire logic [15:0] ext_val_i,
  input wire logic [15:0] ext_oe_i,
  input wire logic wr_dev_i,
  input wire logic wr_dev_oe_i,
  input wire logic wr_ext_i,
  input wire logic wr_ext_oe_i,
  output logic [15:0] pins_o,
  output logic wr_o
);
  import gppm_pkg::*;
  // a clash of two drivers resolves to unknown, as a real board would
  function automatic logic wire_lvl(input logic a, input logic a_oe, input logic b, input logic b_oe);
    if (a_oe && b_oe) begin
      return (a === b) ? a : 1'hx;
    end
    if (a_oe) begin
      return a;
    end
    if (b_oe) begin
      return b;
    end
    // undriven shared lines rest at the board pull-up
    return 1'h1;
  endfunction
  always_comb begin
    for (int i = 0; i < GPPM_PINS; i++) begin
      pins_o[i] = wire_lvl(dev_i.out[i], dev_i.oe[i], ext_val_i[i], ext_oe_i[i]);
    end
    wr_o = wire_lvl(wr_dev_i, wr_dev_oe_i, wr_ext_i, wr_ext_oe_i);
  end
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import gppm_pkg::*;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [1:0] wr_resp = 2'h0;
  logic [31:0] rdata;
  logic mode_sel = 1'h0;
  logic host_wr = 1'h0;
  logic [15:0] lba = 16'h1234;
  logic [15:0] ext_val = 16'h0000;
  logic [15:0] ext_oe = 16'h0000;
  logic [15:0] pins, pin_out, pin_oe;
  logic wr_lvl, wr_out, wr_oe, dmx_wr, irq;
  gppm_pins_t dev;
  int error_cnt = 0;
  int n_tests = 0;
  always #2.5 clk_i = ~clk_i;
  assign dev = '{in: pins, out: pin_out, oe: pin_oe};
  gppm_top gppm_top_inst (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .bus_mode_select_i(mode_sel),
    .wr_dir_i(wr_lvl), .local_bus_address_i(lba), .port_pins_i(pins), .port_pins_o(pin_out),
    .port_pins_oe_o(pin_oe), .wr_dir_o(wr_out), .wr_dir_oe_o(wr_oe), .bus_mode_select_write_o(dmx_wr),
    .interrupt_request_out_o(irq));
  gppm_pins_model gppm_pins_model_inst (.dev_i(dev), .ext_val_i(ext_val), .ext_oe_i(ext_oe), .wr_dev_i(wr_out),
    .wr_dev_oe_i(wr_oe), .wr_ext_i(host_wr), .wr_ext_oe_i(mode_sel), .pins_o(pins), .wr_o(wr_lvl));
  // ****************************************
  // bus cycles and comparison
  // ****************************************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // handshakes are judged at the falling edge: inputs only move at rising edges
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(negedge clk_i);
      ha = awvalid & awready;
      hw = wvalid & wready;
      hb = bready & bvalid;
      wr_resp = bresp;
      @(posedge clk_i);
      if (ha) awvalid <= 1'h0;
      if (hw) wvalid <= 1'h0;
      if (hb) bready <= 1'h0;
    end while (!hb);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha, hr;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(negedge clk_i);
      ha = arvalid & arready;
      hr = rready & rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk_i);
      if (ha) arvalid <= 1'h0;
      if (hr) rready <= 1'h0;
    end while (!hr);
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(what, d, exp);
    chk({what, " resp"}, 32'(r), 32'(GPPM_RESP_OKAY));
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    rchk("cfg", GPPM_OFF_CFG, 32'h0);
    rchk("dir", GPPM_OFF_DIR, 32'h0);
    rchk("mask", GPPM_OFF_MASK, 32'hffff);
    rchk("enable", GPPM_OFF_EN, 32'hffff);
    rchk("mode", GPPM_OFF_MODE, 32'h0);
    @(negedge clk_i);
    chk("addr oe", 32'(pin_oe), 32'hffff);
    chk("addr out", 32'(pin_out), 32'h1234);
    chk("wr oe", 32'(wr_oe), 32'h0);
    chk("wr out", 32'(wr_out), 32'h0);
    chk("pci write", 32'(dmx_wr), 32'h0);
    @(posedge clk_i);
    lba <= 16'hbeef;
    repeat (2) @(negedge clk_i);
    chk("addr follow", 32'(pin_out), 32'hbeef);
    rd(8'h40, d, r);
    chk("unmapped resp", 32'(r), 32'(GPPM_RESP_SLVERR));
    chk("unmapped data", d, 32'h0);
    wr(8'h40, 32'h0);
    chk("unmapped wr resp", 32'(wr_resp), 32'(GPPM_RESP_SLVERR));
  endtask
  task automatic t_port;
    wr(GPPM_OFF_CFG, 32'h1);
    repeat (2) @(negedge clk_i);
    chk("other cfg oe", 32'(pin_oe), 32'h0);
    wr(GPPM_OFF_DIR, 32'h00ff);
    wr(GPPM_OFF_VAL, 32'ha5c3);
    wr(GPPM_OFF_CFG, 32'h4);
    chk("cfg wr resp", 32'(wr_resp), 32'(GPPM_RESP_OKAY));
    ext_oe <= 16'hff00;
    ext_val <= 16'h5a00;
    repeat (4) @(negedge clk_i);
    chk("port oe", 32'(pin_oe), 32'h00ff);
    chk("port out", 32'(pin_out & pin_oe), 32'h00c3);
    rchk("port value", GPPM_OFF_VAL, 32'h5ac3);
    rchk("mode", GPPM_OFF_MODE, 32'h2);
  endtask
  task automatic t_irq;
    wr(GPPM_OFF_MASK, 32'h0);
    wr(GPPM_OFF_CLR, 32'hffff);
    repeat (2) @(negedge clk_i);
    chk("irq idle", 32'(irq), 32'h0);
    @(posedge clk_i);
    ext_val <= 16'h5b00;
    repeat (2) @(negedge clk_i);
    chk("irq early", 32'(irq), 32'h0);
    repeat (3) @(negedge clk_i);
    chk("irq set", 32'(irq), 32'h1);
    rchk("status", GPPM_OFF_STAT, 32'h0100);
    wr(GPPM_OFF_CLR, 32'h0100);
    rchk("clear reads", GPPM_OFF_CLR, 32'h0);
    chk("irq cleared", 32'(irq), 32'h0);
    wr(GPPM_OFF_MASK, 32'h0200);
    ext_val <= 16'h5900;
    repeat (6) @(negedge clk_i);
    chk("irq masked", 32'(irq), 32'h0);
    rchk("masked status", GPPM_OFF_STAT, 32'h0200);
    wr(GPPM_OFF_EN, 32'h0);
    wr(GPPM_OFF_MASK, 32'h0);
    repeat (2) @(negedge clk_i);
    chk("irq disabled", 32'(irq), 32'h0);
    wr(GPPM_OFF_EN, 32'hffff);
    repeat (2) @(negedge clk_i);
    chk("irq enabled", 32'(irq), 32'h1);
  endtask
  task automatic t_bus_mode_select;
    @(posedge clk_i);
    mode_sel <= 1'h1;
    host_wr <= 1'h1;
    repeat (3) @(negedge clk_i);
    chk("bus_mode_select oe", 32'(pin_oe), 32'h0);
    chk("bus_mode_select wr oe", 32'(wr_oe), 32'h0);
    chk("bus_mode_select write", 32'(dmx_wr), 32'h1);
    @(posedge clk_i);
    host_wr <= 1'h0;
    @(negedge clk_i);
    chk("bus_mode_select read", 32'(dmx_wr), 32'h0);
    rchk("mode", GPPM_OFF_MODE, 32'h1);
  endtask
  task automatic tally_and_finish;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    t_reset;
    t_port;
    t_irq;
    t_bus_mode_select;
    tally_and_finish;
  end
  // the scenarios need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    error_cnt++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
